// File: rgb_bridge.sv
// ddr to sdr bridge between the reduced-pin gigabit phy lanes and the tile ports
`timescale 1ns/100ps
module rgb_bridge
	import rgb_pkg::*;
(
	input  wire logic                     clock,
	input  wire logic                     sys_rst,
	input  wire logic                     rst_n,
	input  wire logic                     tx_clk_src,
	input  wire logic                     rx_clk,
	input  wire logic                     bridge_en,
	input  wire logic [1:0]               speed_sel,
	input  wire logic                     tx_clk_delay,
	input  wire logic [rgb_pkg::BYTE_W-1:0] tx_byte,
	input  wire logic                     tx_valid,
	input  wire logic                     tx_error,
	input  wire logic [rgb_pkg::NIBBLE_W-1:0] rx_nib,
	input  wire logic                     rx_ctl,
	input  wire logic [rgb_pkg::GPIO_W-1:0] gpio_out,
	input  wire logic [rgb_pkg::GPIO_W-1:0] gpio_oe,
	output logic      [rgb_pkg::NIBBLE_W-1:0] tx_nib_rise,
	output logic      [rgb_pkg::NIBBLE_W-1:0] tx_nib_fall,
	output logic                          tx_ctl_rise,
	output logic                          tx_ctl_fall,
	output logic                          tx_clk_out,
	output logic [rgb_pkg::GPIO_W-1:0]    pin_out,
	output logic [rgb_pkg::GPIO_W-1:0]    pin_oe,
	output logic [rgb_pkg::BYTE_W-1:0]    rx_byte,
	output logic                          rx_valid,
	output logic                          rx_error,
	output logic [1:0]                    link_speed,
	output logic                          bridge_active
);
	import rgb_pkg::*;

	// ==========================================================
	// reset combine: either source resets all state, mode to RGB_OFF and link speed to SPEED_1000
	logic rst_any;
	assign rst_any = sys_rst | ~rst_n;

	// ==========================================================
	// system-domain state: enable and config synchronised
	typedef struct packed {
		logic       en_s1;
		logic       en_s2;
		logic       dl_s1;
		logic       dl_s2;
		logic [1:0] sp_s1;
		logic [1:0] sp_s2;
		logic [1:0] lsp;
		logic       rv_s1;
		logic       rv_s2;
		logic       rv_old;
		rgb_mode_t  mode;
		logic [GPIO_W-1:0] po;
		logic [GPIO_W-1:0] pe;
	} rgb_sys_t;

	rgb_sys_t s_q, s_d;
	logic     rxv_link;

	always_comb begin
		s_d        = s_q;
		s_d.en_s1  = bridge_en;
		s_d.en_s2  = s_q.en_s1;
		s_d.dl_s1  = tx_clk_delay;
		s_d.dl_s2  = s_q.dl_s1;
		s_d.sp_s1  = speed_sel;
		s_d.sp_s2  = s_q.sp_s1;
		s_d.rv_s1  = rxv_link;
		s_d.rv_s2  = s_q.rv_s1;
		s_d.rv_old = s_q.rv_s2;
		case (s_q.mode)
			RGB_OFF: begin
				if (s_q.en_s2) begin
					s_d.mode = RGB_SYNC;
				end
			end
			RGB_SYNC: begin
				s_d.lsp  = s_q.sp_s2;
				s_d.mode = RGB_RUN;
			end
			RGB_RUN: begin
				if (!s_q.en_s2) begin
					s_d.mode = RGB_OFF;
				end else if (s_q.rv_old && !s_q.rv_s2) begin
					s_d.lsp = s_q.sp_s2;
				end
			end
			default: begin
				s_d.mode = RGB_OFF;
			end
		endcase
		// gpio keeps the pins only while the bridge is off
		if (s_d.mode == RGB_OFF) begin
			s_d.po = gpio_out;
			s_d.pe = gpio_oe;
		end else begin
			s_d.po = '0;
			s_d.pe = '0;
		end
	end

	always_ff @(posedge clock or posedge rst_any) begin
		if (rst_any) begin
			s_q      <= '0;
			s_q.mode <= RGB_OFF;
			s_q.lsp  <= SPEED_1000;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_out       = s_q.po;
	assign pin_oe        = s_q.pe;
	assign link_speed    = s_q.lsp;
	// one-hot run bit read straight from the mode register
	assign bridge_active = s_q.mode[2];

	// ==========================================================
	// transmit clock domain: 125 MHz source, divided by 2 at gigabit and by 16 at both 10 and 100
	typedef struct packed {
		logic       en1;
		logic       en2;
		logic [1:0] sp1;
		logic [1:0] sp2;
		logic       dl1;
		logic       dl2;
		logic [DIV_W-1:0] cnt;
		logic       ck;
		logic       ckd;
	} rgb_tclk_t;

	rgb_tclk_t c_q, c_d;

	always_comb begin
		c_d     = c_q;
		c_d.en1 = bridge_active;
		c_d.en2 = c_q.en1;
		c_d.sp1 = s_q.lsp;
		c_d.sp2 = c_q.sp1;
		c_d.dl1 = s_q.dl_s2;
		c_d.dl2 = c_q.dl1;
		// gigabit toggles every source cycle; 10 and 100 both toggle once per eight-count wrap
		if (!c_q.en2) begin
			c_d.cnt = DIV_RESET;
			c_d.ck  = 1'b0;
		end else if (c_q.sp2 == SPEED_1000) begin
			c_d.cnt = DIV_RESET;
			c_d.ck  = ~c_q.ck;
		end else begin
			c_d.cnt = c_q.cnt + 3'h1;
			if (c_q.cnt == DIV_RESET) begin
				c_d.ck = ~c_q.ck;
			end
		end
		c_d.ckd = c_q.ck;
	end

	always_ff @(posedge tx_clk_src or posedge rst_any) begin
		if (rst_any) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	// delay option moves the edge one source period, out of phase with data
	always_ff @(posedge tx_clk_src or posedge rst_any) begin
		if (rst_any) begin
			tx_clk_out <= 1'b0;
		end else begin
			tx_clk_out <= c_q.dl2 ? c_q.ckd : c_q.ck;
		end
	end

	// ==========================================================
	// transmit data path: on tx_clk_src, the same domain as the clock divider
	rgb_ddr_lane u_tx_lane (
		.clk      (tx_clk_src),
		.rst      (rst_any),
		.byte_in  (tx_byte),
		.valid_in (tx_valid & c_q.en2),
		.error_in (tx_error & c_q.en2),
		.rise_nib (tx_nib_rise),
		.rise_ctl (tx_ctl_rise),
		.fall_nib (tx_nib_fall),
		.fall_ctl (tx_ctl_fall)
	);

	// ==========================================================
	// receive path on the phy's clock: rising then falling capture
	typedef struct packed {
		logic [NIBBLE_W-1:0] lo;
		logic                cr;
		logic [BYTE_W-1:0]   b;
		logic                v;
		logic                e;
	} rgb_rx_t;

	rgb_rx_t r_q, r_d;
	logic [NIBBLE_W-1:0] rx_hi_q;
	logic                rx_cf_q;

	// falling-edge capture of the upper nibble and second control bit
	always_ff @(negedge rx_clk or posedge rst_any) begin
		if (rst_any) begin
			rx_hi_q <= '0;
			rx_cf_q <= 1'b0;
		end else begin
			rx_hi_q <= rx_nib;
			rx_cf_q <= rx_ctl;
		end
	end

	always_comb begin
		r_d    = r_q;
		r_d.lo = rx_nib;
		r_d.cr = rx_ctl;
		r_d.b  = {rx_hi_q, r_q.lo};
		r_d.v  = r_q.cr;
		r_d.e  = r_q.cr ^ rx_cf_q;
	end

	always_ff @(posedge rx_clk or posedge rst_any) begin
		if (rst_any) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign rx_byte  = r_q.b;
	assign rx_valid = r_q.v;
	assign rx_error = r_q.e;
	assign rxv_link = r_q.v;

endmodule

// File: rgb_bridge_asserts.sv
// port assertions for the ddr to sdr bridge
`timescale 1ns/100ps
module rgb_bridge_chk (
	input logic                             clock,
	input logic                             sys_rst,
	input logic                             rst_n,
	input logic                             tx_clk_src,
	input logic                             rx_clk,
	input logic                             bridge_en,
	input logic [1:0]                       speed_sel,
	input logic [rgb_pkg::BYTE_W-1:0]       tx_byte,
	input logic                             tx_valid,
	input logic                             tx_error,
	input logic [rgb_pkg::NIBBLE_W-1:0]     rx_nib,
	input logic                             rx_ctl,
	input logic [rgb_pkg::GPIO_W-1:0]       gpio_out,
	input logic [rgb_pkg::GPIO_W-1:0]       gpio_oe,
	input logic [rgb_pkg::NIBBLE_W-1:0]     tx_nib_rise,
	input logic [rgb_pkg::NIBBLE_W-1:0]     tx_nib_fall,
	input logic                             tx_ctl_rise,
	input logic                             tx_ctl_fall,
	input logic [rgb_pkg::GPIO_W-1:0]       pin_out,
	input logic [rgb_pkg::GPIO_W-1:0]       pin_oe,
	input logic [rgb_pkg::BYTE_W-1:0]       rx_byte,
	input logic                             rx_valid,
	input logic [1:0]                       link_speed,
	input logic                             bridge_active
);
	import rgb_pkg::*;
	logic rs;
	assign rs = sys_rst || !rst_n;
	// ====================
	// checks per clock domain
	property p_tx_lane; @(posedge tx_clk_src) disable iff (rs)
		tx_ctl_rise |-> {tx_nib_fall, tx_nib_rise} == $past(tx_byte) && $past(tx_valid); endproperty
	a_tx_lane: assert property (p_tx_lane) else $error("tx lane mismatch");
	property p_tx_ctl; @(posedge tx_clk_src) disable iff (rs)
		tx_ctl_rise |-> tx_ctl_fall == ($past(tx_valid) ^ $past(tx_error)); endproperty
	a_tx_ctl: assert property (p_tx_ctl) else $error("tx control mismatch");
	property p_rx_lane; @(posedge rx_clk) disable iff (rs)
		rx_valid |-> rx_byte[3:0] == $past(rx_nib, 2) && $past(rx_ctl, 2); endproperty
	a_rx_lane: assert property (p_rx_lane) else $error("rx lane mismatch");
	property p_pins_off; @(posedge clock) disable iff (rs)
		bridge_active && $past(bridge_active) |-> pin_oe == '0 && pin_out == '0; endproperty
	a_pins_off: assert property (p_pins_off) else $error("pins driven while on");
	property p_gpio; @(posedge clock) disable iff (rs)
		!bridge_en [*6] |-> pin_oe == $past(gpio_oe) && pin_out == $past(gpio_out); endproperty
	a_gpio: assert property (p_gpio) else $error("gpio not passed");
	property p_en_on; @(posedge clock) disable iff (rs)
		bridge_en [*4] |-> ##[0:3] bridge_active; endproperty
	a_en_on: assert property (p_en_on) else $error("bridge not taken on");
	property p_rst_val; @(posedge clock) disable iff (rs)
		$fell(sys_rst) |-> link_speed == SPEED_1000 && !bridge_active; endproperty
	a_rst_val: assert property (p_rst_val) else $error("bad reset state");
	property p_speed; @(posedge clock) disable iff (rs)
		$changed(link_speed) |-> link_speed == $past(speed_sel, 3); endproperty
	a_speed: assert property (p_speed) else $error("bad speed change");
endmodule
bind rgb_bridge rgb_bridge_chk rgb_bridge_chk_inst (.*);

// File: rgb_ddr_lane.sv
// one ddr lane pair: byte plus two control bits to nibble and one control bit per edge
`timescale 1ns/100ps
module rgb_ddr_lane
	import rgb_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [BYTE_W-1:0]   byte_in,
	input  wire logic                valid_in,
	input  wire logic                error_in,
	output logic      [NIBBLE_W-1:0] rise_nib,
	output logic                     rise_ctl,
	output logic      [NIBBLE_W-1:0] fall_nib,
	output logic                     fall_ctl
);
	import rgb_pkg::*;

	typedef struct packed {
		logic [NIBBLE_W-1:0] rn;
		logic                rc;
		logic [NIBBLE_W-1:0] fn;
		logic                fc;
	} rgb_lane_t;

	rgb_lane_t s_q, s_d;

	// ==========================================================
	// split byte: low half on rising edge, high half on falling
	always_comb begin
		s_d    = s_q;
		s_d.rn = byte_in[NIBBLE_W-1:0];
		s_d.fn = byte_in[BYTE_W-1:NIBBLE_W];
		s_d.rc = valid_in;
		s_d.fc = valid_in ^ error_in;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rise_nib = s_q.rn;
	assign rise_ctl = s_q.rc;
	assign fall_nib = s_q.fn;
	assign fall_ctl = s_q.fc;
endmodule

// File: rgb_phy_model.sv
// behavioural phy driving the ddr receive lanes
`timescale 1ns/100ps
module rgb_phy_model (
	output logic       rx_clk,
	output logic [3:0] rx_nib,
	output logic       rx_ctl
);
	initial begin
		rx_clk = 1'b0;
		rx_nib = 4'h0;
		rx_ctl = 1'b0;
	end
	// clock stands still between frames; stale rx_nib is inverted while rx_ctl holds
	task automatic send(input logic [7:0] b, input logic v, input logic e);
		rx_nib = b[3:0];
		rx_ctl = v;
		#40 rx_clk = 1'b1;
		#40 rx_nib = b[7:4];
		rx_ctl = v ^ e;
		#40 rx_clk = 1'b0;
		#40 rx_nib = ~rx_nib;
	endtask
endmodule

// File: rgb_pkg.sv
// constants and types shared by the ddr to sdr ethernet bridge
package rgb_pkg;

	// ==========================================================
	// widths
	localparam int unsigned NIBBLE_W = 4;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned GPIO_W   = 12;
	localparam int unsigned DIV_W    = 3;

	// ==========================================================
	// link speeds, fed as config code
	localparam logic [1:0] SPEED_10   = 2'h0;
	localparam logic [1:0] SPEED_100  = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

	// ==========================================================
	// reset values and timing
	localparam logic [DIV_W-1:0] DIV_RESET   = 3'h0;
	localparam int unsigned      RST_HOLD_NS = 100;
	localparam int unsigned      CLK_NS      = 40;
	localparam int unsigned      RST_HOLD_CYC =
		(RST_HOLD_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [2:0] {
		RGB_OFF  = 3'b001,
		RGB_SYNC = 3'b010,
		RGB_RUN  = 3'b100
	} rgb_mode_t;

endpackage

// File: testbench.sv
// self-checking bench for the ddr to sdr bridge
`timescale 1ns/100ps
module testbench;
	import rgb_pkg::*;
	logic                clock, sys_rst, rst_n, tx_clk_src, rx_clk, rx_ctl, tx_clk_out;
	logic                bridge_en, tx_clk_delay, tx_valid, tx_error, tx_ctl_rise, tx_ctl_fall;
	logic                rx_valid, rx_error, bridge_active;
	logic [1:0]          speed_sel, link_speed;
	logic [BYTE_W-1:0]   tx_byte, rx_byte;
	logic [NIBBLE_W-1:0] rx_nib, tx_nib_rise, tx_nib_fall;
	logic [GPIO_W-1:0]   gpio_out, gpio_oe, pin_out, pin_oe;
	int                  n_errors = 0, num_checks = 0, cyc = 0;
	rgb_bridge rgb_bridge_inst (.*);
	rgb_phy_model rgb_phy_model_inst (.*);
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		tx_clk_src = 1'b0;
		#3;
		forever #4 tx_clk_src = ~tx_clk_src;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors = n_errors + 1;
			test_done();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ====================
	// scenarios
	task automatic t_gpio();
		gpio_out = 12'h5a3;
		gpio_oe = 12'hf0f;
		tx_valid = 1'b1;
		repeat (3) @(negedge clock);
		chk({pin_oe[3:0], pin_out}, 16'hf5a3);
		chk(16'(tx_ctl_rise), 16'h0);
		$display("gpio test done");
	endtask
	task automatic t_en();
		bridge_en = 1'b1;
		for (int i = 0; i < 10 && bridge_active !== 1'b1; i++)
			@(negedge clock);
		repeat (2) @(negedge clock);
		chk({3'h0, bridge_active, pin_oe}, 16'h1000);
		$display("enable test done");
	endtask
	task automatic t_tx();
		logic [15:0] exp;
		logic        ck_prev;
		tx_clk_delay = 1'b1;
		ck_prev = 1'b0;
		repeat (4) @(negedge clock);
		for (int i = 0; i < 5; i++) begin
			@(negedge tx_clk_src);
			if (i > 0) begin
				chk({6'h0, tx_nib_fall, tx_nib_rise, tx_ctl_rise, tx_ctl_fall}, exp);
				chk(16'(tx_clk_out ^ ck_prev), 16'h1);
			end
			ck_prev = tx_clk_out;
			tx_byte = 8'h a5 + 8'(i * 37);
			tx_valid = ~i[1];
			tx_error = i[0];
			exp = {6'h0, tx_byte, tx_valid, tx_valid ^ tx_error};
		end
		$display("transmit test done");
	endtask
	task automatic t_rx();
		speed_sel = SPEED_100;
		rgb_phy_model_inst.send(8'h3c, 1'b1, 1'b0);
		rgb_phy_model_inst.send(8'ha5, 1'b1, 1'b1);
		chk({rx_byte, 7'h0, rx_valid}, 16'h3c01);
		rgb_phy_model_inst.send(8'h00, 1'b0, 1'b0);
		chk({rx_byte, 6'h0, rx_valid, rx_error}, 16'ha503);
		rgb_phy_model_inst.send(8'h00, 1'b0, 1'b0);
		for (int i = 0; i < 20 && link_speed !== SPEED_100; i++)
			@(negedge clock);
		chk({12'h0, rx_valid, rx_error, link_speed}, 16'h0001);
		$display("receive test done");
	endtask
	task automatic t_rst();
		@(negedge clock);
		#7 rst_n = 1'b0;
		#1 chk({link_speed, 13'h0, bridge_active}, 16'h8000);
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		$display("reset test done");
	endtask
	initial begin
		{sys_rst, rst_n, bridge_en, speed_sel, tx_clk_delay} = 6'h24;
		{tx_byte, tx_valid, tx_error, gpio_out, gpio_oe} = '0;
		repeat (4) @(negedge clock);
		sys_rst = 1'b0;
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		t_gpio();
		t_en();
		t_tx();
		t_rx();
		t_rst();
		test_done();
	end
endmodule
